//--- hdl/homing_limit_regs.vh
// Purpose: register map, field positions and codes of the homing and travel limit block
// Assumes: AHB-Lite word registers, 32-bit data
// Notes:   included by homing_and_travel_limit_logic.v
`ifndef HOMING_LIMIT_REGS_VH
`define HOMING_LIMIT_REGS_VH
`define REG_CTRL        12'h000
`define REG_HOME_MODE   12'h004
`define REG_ZERO_OFS    12'h008
`define REG_INIT_ADJ    12'h00c
`define REG_LIM_NEG     12'h010
`define REG_LIM_POS     12'h014
`define REG_WINDOW      12'h018
`define REG_ORDER_TGT   12'h01c
`define REG_STATUS      12'h020
`define REG_REF_POINT   12'h024
`define REG_ERR_CODE    12'h028
`define REG_THRESH      12'h02c
// control bits
`define CTRL_HOME_GO    0
`define CTRL_ACK        1
`define CTRL_LIM_EN     2
`define CTRL_REVERSAL   3
`define CTRL_ORDER_GO   4
`define CTRL_REACT_LSB  5
`define CTRL_MODE_LSB   7
// reaction codes
`define REACT_NONE      2'h0
`define REACT_STOP      2'h1
`define REACT_DEENERGIZE 2'h2
// positioning modes
`define POSMODE_ABS     2'h0
`define POSMODE_RESET   2'h1
`define POSMODE_CONT    2'h2
// homing modes
`define HM_NEG_ZERO     8'h21
`define HM_POS_ZERO     8'h22
`define HM_CODED_A      8'h82
`define HM_CODED_B      8'h83
`define HM_CODED_REV_A  8'h84
`define HM_CODED_REV_B  8'h85
// error codes
`define ERR_POS_LIMIT   16'h7323
`define ERR_NEG_LIMIT   16'h7324
// initiator adjustment range in degrees
`define INIT_ADJ_MAX    32'sd360
`define INIT_ADJ_MIN    -32'sd360
`endif

//--- hdl/homing_and_travel_limit_logic.v
// Purpose: final homing modes and software travel limit supervision of a servo axis
// Assumes: one 100 MHz clock, synchronous active-high reset, AHB-Lite register slave
// Notes:   positions are signed 32-bit increments; switches and marks are synchronised
// Contract
// - mode 33: search negative, first motor zero point becomes machine zero
// - mode 34: search positive, first motor zero point becomes machine zero
// - modes 130/131: absolute position from coded mark spacing, then halt in place
// - modes 132/133: same coded search, reversing at reversal switches
// - reversal option: brake and reverse when current or following error threshold reached (the code does this in modes 33/34 only)
// - home initiator offset in motor degrees, range -360..360, default 0
// - reference point equals found machine zero plus machine zero offset
// - new machine zero offset takes effect only at next completed homing
// - limit reaction: none, stop, or stop and de-energize; de-energize default
// - absolute mode rejects orders with target outside limits around reference
// - reset mode does no software limit checking
// - continuous mode checks each move's target relative to present position
// - limit error when supervised position passes limit; setpoint energized, actual otherwise
// - after ack while de-energized, no new error until beyond window from limit
// - positive limit reports 0x7323, negative limit reports 0x7324
// - limit error generation enabled or disabled by configuration
// - supervision inactive after power-on until a homing run sets reference
// - supervision suspended during a homing run
// - multiturn absolute feedback enforces limits right after power-on
// - limit errors disabled: all movements allowed
// - after acknowledged error only inward moves run; outward moves blocked, new error
//
// Our own choices: the register addresses and register access over AHB-Lite.
`include "homing_limit_regs.vh"
`default_nettype none
module homing_and_travel_limit_logic #(
  parameter integer DEG_PER_REV  = 360,
  parameter integer COUNTS_REV   = 4096,
  parameter integer CODE_BASE    = 1000
) (
  input  wire        i_core_clk,
  input  wire        i_srst,
  // ahb-lite slave
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  // feedback and switches
  input  wire [31:0] i_actual_pos,
  input  wire [31:0] i_setpoint_pos,
  input  wire        i_motor_zero,
  input  wire        i_coded_mark,
  input  wire        i_home_switch,
  input  wire        i_rev_neg,
  input  wire        i_rev_pos,
  input  wire        i_threshold_hit,
  input  wire        i_energized,
  input  wire        i_multiturn,
  // motion interface
  output reg         o_homing_active,
  output reg         o_move_dir_pos,
  output reg         o_use_homing_profile,
  output reg         o_halt,
  output reg         o_deenergize,
  output reg         o_order_go,
  output reg  [31:0] o_order_target,
  output reg         o_limit_error,
  output reg         o_referenced
);

  // homing state machine
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SRCH  = 3'h1;
  localparam [2:0] ST_BRAKE = 3'h2;
  localparam [2:0] ST_CODE2 = 3'h3;
  localparam [2:0] ST_DONE  = 3'h4;

  // signed compare, used for both limits
  function beyond;
    input [31:0] a;
    input [31:0] b;
    begin
      beyond = ($signed(a) > $signed(b));
    end
  endfunction

  // clamp of the initiator adjustment
  function [31:0] clamp_adj;
    input [31:0] v;
    begin
      if ($signed(v) > `INIT_ADJ_MAX)
        clamp_adj = `INIT_ADJ_MAX;
      else if ($signed(v) < `INIT_ADJ_MIN)
        clamp_adj = `INIT_ADJ_MIN;
      else
        clamp_adj = v;
    end
  endfunction

  // two-flop synchronisers for pins
  reg [6:0] sync1;
  reg [6:0] sync2;
  reg [6:0] sync_d;
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      sync_d <= 7'h00;
    end else begin
      sync1 <= {i_multiturn, i_threshold_hit, i_rev_pos, i_rev_neg, i_home_switch, i_coded_mark, i_motor_zero};
      sync2 <= sync1;
      sync_d <= sync2;
    end
  end
  wire zero_rise  = sync2[0] & ~sync_d[0];
  wire mark_rise  = sync2[1] & ~sync_d[1];
  wire rev_neg    = sync2[3];
  wire rev_pos    = sync2[4];
  wire thr_rise   = sync2[5] & ~sync_d[5];
  wire multiturn  = sync2[6];

  // configuration, status and internal state registers
  reg [31:0] ctrl;
  reg [7:0]  home_mode;
  reg [31:0] zero_ofs;
  reg [31:0] init_adj;
  reg [31:0] lim_neg;
  reg [31:0] lim_pos;
  reg [31:0] window;
  reg [31:0] thresh;
  reg [15:0] err_code;
  reg [31:0] ref_point;
  reg [31:0] mark_pos;
  reg [2:0]  hstate;
  reg        acked;
  reg        dir_block_pos;
  reg        dir_block_neg;
  reg        mt_seen;

  wire       lim_en  = ctrl[`CTRL_LIM_EN];
  wire       rev_opt = ctrl[`CTRL_REVERSAL];
  wire [1:0] react   = ctrl[`CTRL_REACT_LSB+1:`CTRL_REACT_LSB];
  wire [1:0] posmode = ctrl[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];

  // ahb address phase capture
  reg        dp_valid;
  reg        dp_write;
  reg [11:0] dp_addr;
  wire       ap_take = i_hsel & i_htrans[1] & i_hready;
  wire       wr_now  = dp_valid & dp_write;
  wire       go_home = wr_now & (dp_addr == `REG_CTRL) & i_hwdata[`CTRL_HOME_GO];
  wire       ack_now = wr_now & (dp_addr == `REG_CTRL) & i_hwdata[`CTRL_ACK];
  wire       go_ord  = wr_now & (dp_addr == `REG_CTRL) & i_hwdata[`CTRL_ORDER_GO];

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
    end else begin
      dp_valid <= ap_take;
      dp_write <= i_hwrite;
      dp_addr <= {i_haddr[11:2], 2'b00};
    end
  end

  // register writes; home/ack/order bits self clear
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl <= {23'h0, `POSMODE_ABS, `REACT_DEENERGIZE, 5'h00};
      home_mode <= `HM_NEG_ZERO;
      zero_ofs <= 32'h0;
      init_adj <= 32'h0;
      lim_neg <= 32'h0;
      lim_pos <= 32'h0;
      window <= 32'h0;
      thresh <= 32'h0;
      o_order_target <= 32'h0;
    end else if (wr_now) begin
      case (dp_addr)
        `REG_CTRL:      ctrl <= {i_hwdata[31:5], 5'h00} | (i_hwdata & 32'h0000000c);
        `REG_HOME_MODE: home_mode <= i_hwdata[7:0];
        `REG_ZERO_OFS:  zero_ofs <= i_hwdata;
        `REG_INIT_ADJ:  init_adj <= clamp_adj(i_hwdata);
        `REG_LIM_NEG:   lim_neg <= i_hwdata;
        `REG_LIM_POS:   lim_pos <= i_hwdata;
        `REG_WINDOW:    window <= i_hwdata;
        `REG_ORDER_TGT: o_order_target <= i_hwdata;
        `REG_THRESH:    thresh <= i_hwdata;
        default:        ctrl <= ctrl;
      endcase
    end
  end

  // ahb read data and response, zero wait
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_hrdata <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= 32'h0;
      if (ap_take && !i_hwrite) begin
        case ({i_haddr[11:2], 2'b00})
          `REG_CTRL:      o_hrdata <= ctrl;
          `REG_HOME_MODE: o_hrdata <= {24'h0, home_mode};
          `REG_ZERO_OFS:  o_hrdata <= zero_ofs;
          `REG_INIT_ADJ:  o_hrdata <= init_adj;
          `REG_LIM_NEG:   o_hrdata <= lim_neg;
          `REG_LIM_POS:   o_hrdata <= lim_pos;
          `REG_WINDOW:    o_hrdata <= window;
          `REG_ORDER_TGT: o_hrdata <= o_order_target;
          `REG_STATUS:    o_hrdata <= {24'h0, hstate, acked, o_limit_error, o_referenced, o_homing_active, o_halt};
          `REG_REF_POINT: o_hrdata <= ref_point;
          `REG_ERR_CODE:  o_hrdata <= {16'h0, err_code};
          `REG_THRESH:    o_hrdata <= thresh;
          default:        o_hrdata <= 32'h0;
        endcase
      end
    end
  end

  // homing mode decode
  wire mode_coded = (home_mode == `HM_CODED_A) | (home_mode == `HM_CODED_B) |
                    (home_mode == `HM_CODED_REV_A) | (home_mode == `HM_CODED_REV_B);
  wire mode_rev   = (home_mode == `HM_CODED_REV_A) | (home_mode == `HM_CODED_REV_B);
  wire start_pos  = (home_mode == `HM_POS_ZERO) | (home_mode == `HM_CODED_B) | (home_mode == `HM_CODED_REV_B);
  // coded spacing: increments between marks map to absolute position
  wire [31:0] spacing   = i_actual_pos - mark_pos;
  wire [31:0] coded_abs = spacing * CODE_BASE;
  // signed scaling, so a negative adjustment moves the point back
  wire [31:0] adj_cnt   = ($signed(init_adj) * COUNTS_REV) / DEG_PER_REV;

  // homing sequencer
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      hstate <= ST_IDLE;
      o_homing_active <= 1'b0;
      o_use_homing_profile <= 1'b0;
      o_move_dir_pos <= 1'b0;
      o_halt <= 1'b0;
      o_referenced <= 1'b0;
      ref_point <= 32'h0;
      mark_pos <= 32'h0;
      mt_seen <= 1'b0;
    end else begin
      // multiturn feedback counts as referenced from power-on
      if (multiturn && !mt_seen) begin
        mt_seen <= 1'b1;
        o_referenced <= 1'b1;
      end
      case (hstate)
        ST_IDLE: begin
          if (go_home) begin
            hstate <= ST_SRCH;
            o_homing_active <= 1'b1;
            o_use_homing_profile <= 1'b1;
            o_move_dir_pos <= start_pos;
            o_halt <= 1'b0;
          end
        end
        ST_SRCH: begin
          if (rev_opt && thr_rise && !mode_coded) begin
            hstate <= ST_BRAKE;
          end else if (mode_rev && ((o_move_dir_pos && rev_pos) || (!o_move_dir_pos && rev_neg))) begin
            o_move_dir_pos <= ~o_move_dir_pos;
          end else if (mode_coded && mark_rise) begin
            mark_pos <= i_actual_pos;
            hstate <= ST_CODE2;
          end else if (!mode_coded && zero_rise) begin
            ref_point <= i_actual_pos + adj_cnt + zero_ofs;
            hstate <= ST_DONE;
          end
        end
        ST_BRAKE: begin
          o_halt <= 1'b1;
          o_move_dir_pos <= ~o_move_dir_pos;
          hstate <= ST_SRCH;
        end
        ST_CODE2: begin
          o_halt <= 1'b0;
          if (mode_rev && ((o_move_dir_pos && rev_pos) || (!o_move_dir_pos && rev_neg))) begin
            o_move_dir_pos <= ~o_move_dir_pos;
          end else if (mark_rise) begin
            ref_point <= i_actual_pos - coded_abs + zero_ofs;
            hstate <= ST_DONE;
          end
        end
        ST_DONE: begin
          o_halt <= 1'b1;
          o_homing_active <= 1'b0;
          o_use_homing_profile <= 1'b0;
          o_referenced <= 1'b1;
          hstate <= ST_IDLE;
        end
        default: hstate <= ST_IDLE;
      endcase
      // a brake holds for one cycle only, then the search runs on
      if (hstate == ST_SRCH) o_halt <= 1'b0;
    end
  end

  // limit supervision
  wire        sup_on  = lim_en & o_referenced & ~o_homing_active & (posmode != `POSMODE_RESET);
  wire [31:0] sup_pos = i_energized ? i_setpoint_pos : i_actual_pos;
  wire [31:0] abs_pos = lim_pos + ref_point;
  wire [31:0] abs_neg = lim_neg + ref_point;
  wire [31:0] rel_pos = lim_pos + i_actual_pos;
  wire [31:0] rel_neg = lim_neg + i_actual_pos;
  wire [31:0] hi_lim  = (posmode == `POSMODE_CONT) ? rel_pos : abs_pos;
  wire [31:0] lo_lim  = (posmode == `POSMODE_CONT) ? rel_neg : abs_neg;
  // hysteresis widens the trip point after an acknowledged de-energized error
  wire        hyst    = acked & ~i_energized;
  wire        over_p  = beyond(sup_pos, hyst ? abs_pos + window : abs_pos);
  wire        over_n  = beyond(hyst ? abs_neg - window : abs_neg, sup_pos);
  wire        tgt_hi  = beyond(o_order_target, hi_lim);
  wire        tgt_lo  = beyond(lo_lim, o_order_target);
  wire        inward  = (dir_block_pos & ~beyond(o_order_target, sup_pos)) |
                        (dir_block_neg & ~beyond(sup_pos, o_order_target));
  wire        blocked = (dir_block_pos | dir_block_neg) & ~inward;
  wire        reject  = sup_on & ~(dir_block_pos | dir_block_neg) & (tgt_hi | tgt_lo);

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_limit_error <= 1'b0;
      o_deenergize <= 1'b0;
      o_order_go <= 1'b0;
      err_code <= 16'h0;
      acked <= 1'b0;
      dir_block_pos <= 1'b0;
      dir_block_neg <= 1'b0;
    end else begin
      o_order_go <= 1'b0;
      // acknowledge first, so a refusal in the same write still wins
      if (ack_now) begin
        o_limit_error <= 1'b0;
        o_deenergize <= 1'b0;
        acked <= 1'b1;
      end
      // order release: all allowed when limits disabled
      if (go_ord) begin
        if (!sup_on || (!reject && !blocked)) begin
          o_order_go <= 1'b1;
        end else begin
          o_limit_error <= 1'b1;
          err_code <= tgt_hi | dir_block_pos ? `ERR_POS_LIMIT : `ERR_NEG_LIMIT;
        end
      end
      // leave hysteresis and direction block once back inside
      if (sup_on && !over_p && !over_n && !beyond(sup_pos, abs_pos) && !beyond(abs_neg, sup_pos)) begin
        dir_block_pos <= 1'b0;
        dir_block_neg <= 1'b0;
        acked <= 1'b0;
      end
      // position trip; set wins over acknowledge
      // after a de-energized acknowledge the widened trip point still fires
      if (sup_on && !o_limit_error && (!(dir_block_pos | dir_block_neg) || hyst) && (over_p || over_n)) begin
        o_limit_error <= 1'b1;
        err_code <= over_p ? `ERR_POS_LIMIT : `ERR_NEG_LIMIT;
        dir_block_pos <= over_p;
        dir_block_neg <= over_n;
        o_deenergize <= (react == `REACT_DEENERGIZE);
        acked <= 1'b0;
      end
      if (react == `REACT_NONE) o_deenergize <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- sim/homing_limit_asserts.sv
// Purpose: port assertions of the homing and travel limit block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the block after the module
`default_nettype none
module homing_limit_checker (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_homing_active,
  input wire logic o_use_homing_profile,
  input wire logic o_halt,
  input wire logic o_deenergize,
  input wire logic o_order_go,
  input wire logic o_limit_error,
  input wire logic o_referenced
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  // end of a run and what must stand by then
  sequence s_home_end;
    $fell(o_homing_active);
  endsequence
  sequence s_home_result;
    o_referenced && o_halt;
  endsequence
  sequence s_err_rise;
    $rose(o_limit_error);
  endsequence
  AST_READY: assert property (o_hreadyout) else $error("wait state inserted");
  AST_OKAY: assert property (!o_hresp) else $error("error response");
  AST_PROFILE: assert property (o_homing_active |-> o_use_homing_profile)
    else $error("homing without homing profile");
  AST_HOME_DONE: assert property (s_home_end |-> s_home_result)
    else $error("run ended unreferenced or moving");
  AST_NO_ERR_HOMING: assert property (o_homing_active |-> not s_err_rise)
    else $error("limit error during homing");
  AST_NO_ERR_UNREF: assert property (!o_referenced |-> not s_err_rise)
    else $error("limit error on unreferenced axis");
  AST_DEEN: assert property ($rose(o_deenergize) |-> o_limit_error)
    else $error("de-energize without limit error");
  AST_GO_PULSE: assert property (o_order_go |=> !o_order_go)
    else $error("order release longer than one cycle");
endmodule
bind homing_and_travel_limit_logic homing_limit_checker i_chk (.i_core_clk, .i_srst, .o_hreadyout,
  .o_hresp, .o_homing_active, .o_use_homing_profile, .o_halt, .o_deenergize, .o_order_go,
  .o_limit_error, .o_referenced);
`default_nettype wire

//--- sim/axis_feedback_model.sv
// Purpose: motor feedback, marks, reversal switches and threshold of the axis
// Assumes: one count of travel per clock while the block asks for motion
// Notes:   zero marks every REV counts, coded marks every MARK counts
`default_nettype none
module axis_feedback_model #(
  parameter int REV    = 64,
  parameter int MARK   = 40,
  parameter int REV_LO = 8,
  parameter int REV_HI = 1000
) (
  input  wire logic        i_clk,
  input  wire logic        i_move,
  input  wire logic        i_dir_pos,
  input  wire logic        i_load,
  input  wire logic [31:0] i_load_val,
  input  wire logic [31:0] i_lag,
  input  wire logic        i_bump,
  output logic      [31:0] o_actual,
  output logic      [31:0] o_setpoint,
  output logic             o_motor_zero,
  output logic             o_coded_mark,
  output logic             o_rev_neg,
  output logic             o_rev_pos,
  output logic             o_threshold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [31:0] pos = 32'sh0;
  // travel, or a jump set by the bench
  always @(posedge i_clk) begin
    if (i_load) begin
      pos <= i_load_val;
    end else if (i_move) begin
      pos <= i_dir_pos ? pos + 32'sh1 : pos - 32'sh1;
    end
  end
  // actual trails the setpoint by the lag
  assign o_setpoint   = pos;
  assign o_actual     = pos - i_lag;
  assign o_motor_zero = (pos % REV) == 0;
  assign o_coded_mark = (pos % MARK) == 0;
  assign o_rev_neg    = pos <= REV_LO;
  assign o_rev_pos    = pos >= REV_HI;
  assign o_threshold  = i_bump;
endmodule
`default_nettype wire

//--- sim/tb.sv
// Purpose: self-checking bench of the homing and travel limit block
// Assumes: 100 MHz clock, single-word AHB-Lite transfers
// Notes:   homing results allow a slack of a few counts
`include "homing_limit_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, en = 1'b0, mt = 1'b0;
  logic        ld = 1'b0, bump = 1'b0, d;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, ldv = 32'h0, lag = 32'h0, ctl, rd;
  logic [7:0]  cm [4] = '{`HM_CODED_A, `HM_CODED_B, `HM_CODED_REV_A, `HM_CODED_REV_B};
  wire  [31:0] hrdata, act, sp, tgt;
  wire         hrdy, hresp, mz, mk, rn, rp, th, hom, dp, prof, halt, deen, go, err, refd;
  int          mismatches = 0, n_tests = 0, ofs, r;
  homing_and_travel_limit_logic #(.CODE_BASE(1)) i_dut (.i_core_clk(clk), .i_srst(srst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_actual_pos(act), .i_setpoint_pos(sp), .i_motor_zero(mz), .i_coded_mark(mk),
    .i_home_switch(1'b0), .i_rev_neg(rn), .i_rev_pos(rp), .i_threshold_hit(th), .i_energized(en),
    .i_multiturn(mt), .o_homing_active(hom), .o_move_dir_pos(dp), .o_use_homing_profile(prof),
    .o_halt(halt), .o_deenergize(deen), .o_order_go(go), .o_order_target(tgt),
    .o_limit_error(err), .o_referenced(refd));
  axis_feedback_model i_fb (.i_clk(clk), .i_move(hom & ~halt), .i_dir_pos(dp), .i_load(ld),
    .i_load_val(ldv), .i_lag(lag), .i_bump(bump), .o_actual(act), .o_setpoint(sp),
    .o_motor_zero(mz), .o_coded_mark(mk), .o_rev_neg(rn), .o_rev_pos(rp), .o_threshold(th));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] b1(input logic x);
    return {31'h0, x};
  endfunction
  function automatic logic [31:0] near(input logic [31:0] a, input int e);
    return b1(($signed(a) - e <= 6) && ($signed(a) - e >= -6));
  endfunction
  // one single transfer, held until hready is seen
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic setpos(input int p, input int l, input logic e);
    @(posedge clk);
    ld <= 1'b1;
    ldv <= p;
    lag <= l;
    en <= e;
    @(posedge clk);
    ld <= 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic home(input logic [7:0] m, input int p);
    int n;
    setpos(p, 0, en);
    bus(1'b1, `REG_HOME_MODE, {24'h0, m});
    bus(1'b1, `REG_CTRL, ctl | 32'h1);
    for (n = 0; n < 9 && hom !== 1'b1; n++) @(negedge clk);
    d = dp;
    for (n = 0; n < 3000 && hom === 1'b1; n++) @(negedge clk);
    chk(b1(refd & halt & ~hom), 32'h1);
  endtask
  task automatic order(input int t, input logic ok, input logic [31:0] code);
    logic g, e;
    g = 1'b0;
    e = 1'b0;
    bus(1'b1, `REG_ORDER_TGT, t);
    bus(1'b1, `REG_CTRL, ctl | 32'h10);
    repeat (4) begin
      @(negedge clk);
      g |= go;
      e |= err;
    end
    chk({30'h0, g, e}, {30'h0, ok, ~ok});
    chk(tgt, t);
    if (!ok) rdc(`REG_ERR_CODE, code);
    if (!ok) bus(1'b1, `REG_CTRL, ctl | 32'h2);
  endtask
  task automatic setctl(input logic [31:0] c);
    ctl = c;
    bus(1'b1, `REG_CTRL, c);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(95));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rdc(`REG_CTRL, 32'h40);
    rdc(`REG_INIT_ADJ, 32'h0);
    setctl(32'h44);
    bus(1'b1, `REG_LIM_NEG, -200);
    bus(1'b1, `REG_LIM_POS, 300);
    bus(1'b1, `REG_WINDOW, 50);
    setpos(5000, 0, 1'b1);
    chk(b1(err | refd), 32'h0);
    bus(1'b1, `REG_INIT_ADJ, 500);
    rdc(`REG_INIT_ADJ, 32'd360);
    bus(1'b1, `REG_INIT_ADJ, -500);
    rdc(`REG_INIT_ADJ, -32'sd360);
    bus(1'b1, `REG_INIT_ADJ, 0);
    ofs = -int'($urandom % 64);
    bus(1'b1, `REG_ZERO_OFS, ofs);
    home(`HM_NEG_ZERO, 100);
    chk(b1(d), 32'h0);
    bus(1'b0, `REG_REF_POINT, 0);
    r = rd;
    chk(near(rd, 64 + ofs), 32'h1);
    ofs -= 10;
    bus(1'b1, `REG_ZERO_OFS, ofs);
    rdc(`REG_REF_POINT, r);
    home(`HM_POS_ZERO, 100);
    chk(b1(d), 32'h1);
    bus(1'b0, `REG_REF_POINT, 0);
    chk(near(rd, 128 + ofs), 32'h1);
    ctl = 32'h4c;
    fork
      home(`HM_NEG_ZERO, 100);
      begin
        wait (hom === 1'b1);
        repeat (5) @(posedge clk);
        bump <= 1'b1;
        @(posedge clk);
        bump <= 1'b0;
        repeat (8) @(negedge clk);
        chk(b1(dp), 32'h1);
      end
    join
    bus(1'b0, `REG_REF_POINT, 0);
    chk(near(rd, 128 + ofs), 32'h1);
    ctl = 32'h44;
    foreach (cm[i]) begin
      home(cm[i], 20);
      r = act;
      repeat (20) @(negedge clk);
      chk(act, r);
    end
    home(`HM_POS_ZERO, 100);
    r = 128 + ofs;
    for (int i = 0; i < 6; i++) order(r - 190 + int'($urandom % 480), 1'b1, 0);
    order(r + 320, 1'b0, `ERR_POS_LIMIT);
    order(r - 220, 1'b0, `ERR_NEG_LIMIT);
    setpos(r + 200, 0, 1'b1);
    setctl(32'h144);
    order(r + 450, 1'b1, 0);
    order(r - 50, 1'b0, `ERR_NEG_LIMIT);
    setctl(32'hc4);
    order(r + 5000, 1'b1, 0);
    setctl(32'h40);
    order(r + 5000, 1'b1, 0);
    setctl(32'h24);
    setpos(r - 230, 0, 1'b1);
    chk(b1(err & ~deen), 32'h1);
    rdc(`REG_ERR_CODE, `ERR_NEG_LIMIT);
    bus(1'b1, `REG_CTRL, ctl | 32'h2);
    order(r - 300, 1'b0, `ERR_NEG_LIMIT);
    order(r - 100, 1'b1, 0);
    setpos(r, 0, 1'b1);
    bus(1'b1, `REG_CTRL, ctl | 32'h2);
    setctl(32'h44);
    setpos(r + 320, 100, 1'b0);
    chk(b1(err), 32'h0);
    setpos(r + 320, 100, 1'b1);
    chk(b1(err & deen), 32'h1);
    rdc(`REG_ERR_CODE, `ERR_POS_LIMIT);
    setpos(r + 320, 0, 1'b0);
    bus(1'b1, `REG_CTRL, ctl | 32'h2);
    repeat (8) @(negedge clk);
    chk(b1(err), 32'h0);
    setpos(r + 380, 0, 1'b0);
    chk(b1(err), 32'h1);
    @(posedge clk);
    srst <= 1'b1;
    mt <= 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(negedge clk);
    chk(b1(refd), 32'h1);
    setctl(32'h44);
    bus(1'b1, `REG_LIM_NEG, -200);
    bus(1'b1, `REG_LIM_POS, 300);
    setpos(5000, 0, 1'b1);
    chk(b1(err), 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
